/* shared/diag_pkg.sv */
// Purpose: Constants and types for the acquisition diagnostic checks
// Assumes: 50 MHz core clock, 16-bit register port with byte addresses
// Notes:   Offsets are byte addresses, one aligned word per register
package diag_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_DIAG_CONFIG = 8'h00; // Both select fields
    localparam logic [7:0] OFS_RESULT_1    = 8'h04; // First result
    localparam logic [7:0] OFS_RESULT_2    = 8'h08; // Second result
    localparam logic [7:0] OFS_ACQ_CONFIG  = 8'h0C; // Accuracy, cal enable
    localparam logic [7:0] OFS_SCAN_CTRL   = 8'h10; // Scan configuration
    localparam logic [7:0] OFS_TEMP_THR    = 8'h14; // Die temp threshold
    localparam logic [7:0] OFS_ACC_OV_THR  = 8'h18; // Accuracy OV code
    localparam logic [7:0] OFS_ACC_UV_THR  = 8'h1C; // Accuracy UV code
    localparam logic [7:0] OFS_FAULT_2     = 8'h20; // Sticky alert flags
    // ------------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------------
    localparam int BIT_ACC_EN   = 0; // comparator_accuracy_enable
    localparam int BIT_CAL_EN   = 1; // adc_calibration_enable
    localparam int BIT_F_TEMP   = 0; // die_overtemp_alert
    localparam int BIT_F_ACC_OV = 1; // accuracy_ov_alert
    localparam int BIT_F_ACC_UV = 2; // accuracy_uv_alert
    localparam logic [3:0] SEL_TEMP   = 4'h1;
    localparam logic [3:0] SEL_VAA    = 4'h2;
    localparam logic [3:0] SEL_ALTERNATE_REFERENCE = 4'h3;
    localparam logic [3:0] SEL_PATH   = 4'h4;
    localparam logic [2:0] SCAN_CMP_A = 3'h1; // Scans using comparator
    localparam logic [2:0] SCAN_CMP_B = 3'h2;
    localparam logic [9:0] PATH_DAC_CODE = 10'h1D8;
    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [13:0] TEMP_THR_RST = 14'h3FFF; // Plain default
    localparam logic [9:0]  ACC_THR_RST  = 10'h1D8;
    localparam int CLK_MHZ        = 50;
    localparam int TEMP_PERIOD_US = 1000; // 1 ms monitoring interval
    localparam int TEMP_CYCLES    = TEMP_PERIOD_US * CLK_MHZ;
    localparam int SETTLE_CYCLES  = 8;    // DAC and comparator settling
    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        IN_NONE, IN_TEMPERATURE_PROPORTIONAL_SOURCE, IN_VREF, IN_ALTERNATE_REFERENCE, IN_PREAMP
    } adc_in_t;
    typedef struct packed {
        adc_in_t in_sel;      // ADC input selection
        logic    ref_vaa;     // Supply rail used as ADC reference
        logic    force_unip;  // Override configured polarity to unipolar
        logic    second_level_shift_amp_vref; // Main reference into second level shifter
    } afe_ctrl_t;
    typedef enum {K_TEMP, K_DIAG1, K_DIAG2} conv_kind_t;
endpackage : diag_pkg

/* tb/testbench.sv */
// Purpose: Self-checking bench for diag_checks with a queue-based model
// Assumes: Tick shortened to 100 cycles; ADC answered by a responder
// Notes:   Select code 1 in the idle field keeps ticks out of diag tests
`timescale 1ns/1ns
module testbench;
    import diag_pkg::*;
    logic        core_clk = 1'b0;
    logic        resetn   = 1'b0;
    logic        wr = 1'b0, rd = 1'b0, diag_req = 1'b0, diag_slot = 1'b0;
    logic        scan_end = 1'b0, adc_done = 1'b0, comp_pin = 1'b0;
    logic [7:0]  addr     = 8'h00;
    logic [15:0] wdata    = 16'h0000;
    logic [13:0] adc_data = 14'h0000;
    logic [13:0] temp_val = 14'h0000; // Die temperature the ADC reports
    logic [15:0] rdata, rv;
    logic        adc_start, busy;
    afe_ctrl_t   afe, afe_seen;
    logic [9:0]  dac_code, dac_seen;
    int          bad_count = 0, checked = 0, seed = 1718, corr = 0;
    int          res_q[$]; // Model: diagnostic codes handed to the block
    always #10 core_clk = ~core_clk;
    // Stand-in answers inside the calibrated host pass windows, which lie
    // within the uncalibrated ones
    function automatic logic [13:0] in_window(input adc_in_t s,
                                              input logic [31:0] r);
        case (s)
            IN_VREF:   return 14'(32'h13E4 + r % 32'h0193);
            IN_ALTERNATE_REFERENCE: return 14'(32'h0FD5 + r % 32'h0026);
            default:   return 14'(32'h1BC0 + r % 32'h08C1);
        endcase
    endfunction : in_window
    diag_checks #(.TICK_CYCLES(100)) u_diag_checks (.core_clk(core_clk),
        .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .diag_req(diag_req), .diag_slot(diag_slot),
        .scan_end(scan_end), .adc_start(adc_start), .adc_done(adc_done),
        .adc_data(adc_data), .afe(afe), .dac_code(dac_code),
        .comp_pin(comp_pin), .busy(busy));
    // ADC stand-in: answers one cycle after each start, random data except temp_val for temperature
    always @(posedge core_clk) begin
        adc_done <= adc_start;
        if (adc_start) begin
            afe_seen = afe;
            dac_seen = dac_code;
            adc_data <= afe.in_sel == IN_TEMPERATURE_PROPORTIONAL_SOURCE ? temp_val
                      : in_window(afe.in_sel, {$random(seed)});
            if (afe.in_sel != IN_TEMPERATURE_PROPORTIONAL_SOURCE) res_q.push_back(0);
        end
        if (adc_done && afe_seen.in_sel != IN_TEMPERATURE_PROPORTIONAL_SOURCE) res_q[$] = adc_data;
    end
    task automatic cmp(input string what, input logic [15:0] e, g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : cmp
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk) {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge core_clk) wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk) {addr, rd} <= {a, 1'b1};
        @(posedge core_clk) rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_cyc
    task automatic wait_idle;
        int n;
        n = 0;
        wait_cyc(2);
        while (busy !== 1'b0 && n < 200) begin
            wait_cyc(1);
            n++;
        end
        if (n == 200) bad_count++;
    endtask : wait_idle
    // One diagnostic request through the chosen slot
    task automatic diag(input logic [3:0] c, input logic s);
        afe_ctrl_t e;
        wr_reg(OFS_DIAG_CONFIG, s ? {8'h00, c, 4'h1} : {8'h00, 4'h1, c});
        wait_idle();
        @(posedge core_clk) {diag_req, diag_slot} <= {1'b1, s};
        @(posedge core_clk) diag_req <= 1'b0;
        #1 cmp("busy", 16'h0001, 16'(busy));
        wait_idle();
        e = '0;
        e.in_sel = c == SEL_VAA ? IN_VREF
                 : c == SEL_ALTERNATE_REFERENCE ? IN_ALTERNATE_REFERENCE : IN_PREAMP;
        e.ref_vaa = (c == SEL_VAA);
        e.force_unip = (c == SEL_ALTERNATE_REFERENCE);
        e.second_level_shift_amp_vref = (c == SEL_PATH);
        cmp("afe", 16'(e), 16'(afe_seen));
        if (c == SEL_PATH) cmp("dac", 16'h01D8, 16'(dac_seen));
        rd_reg(s ? OFS_RESULT_2 : OFS_RESULT_1, rv);
        cmp("result", 16'(res_q.pop_back() << 2), rv);
    endtask : diag
    task automatic print_verdict;
        $display("checked %0d bad %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict
    initial begin
        wait_cyc(5000);
        bad_count++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        rd_reg(OFS_ACC_OV_THR, rv);
        cmp("ov_thr", 16'h01D8, rv);
        wr_reg(OFS_ACQ_CONFIG, 16'h0002);
        for (int c = 2; c < 5; c++) diag(4'(c), 1'b0);
        diag(SEL_PATH, 1'b1);
        // Host folds the path error into the accuracy thresholds only,
        // never into auxiliary-input thresholds
        corr = int'(real'(int'(rv >> 2) - 8224) * 1023.0 / 212992.0);
        wr_reg(OFS_ACC_OV_THR, 16'(32'h01D8 + corr));
        wr_reg(OFS_ACC_UV_THR, 16'(32'h01D8 + corr));
        // Hot die while code 1 is still selected: no alert may appear
        temp_val = 14'h0200;
        wr_reg(OFS_TEMP_THR, 16'h0100);
        wr_reg(OFS_FAULT_2, 16'h0007);
        wait_cyc(250);
        rd_reg(OFS_FAULT_2, rv);
        cmp("fault", 16'h0000, rv);
        wr_reg(OFS_DIAG_CONFIG, 16'h0000);
        wait_cyc(250);
        rd_reg(OFS_FAULT_2, rv);
        cmp("fault", 16'h0001, rv);
        // Accuracy check: scan configs 1, 2 run it, 3 does not
        wr_reg(OFS_TEMP_THR, 16'h3FFF);
        wr_reg(OFS_ACQ_CONFIG, 16'h0001);
        for (int i = 0; i < 3; i++) begin
            wr_reg(OFS_SCAN_CTRL, 16'(i + 1));
            comp_pin <= (i != 1);
            wait_idle();
            wr_reg(OFS_FAULT_2, 16'h0007);
            @(posedge core_clk) scan_end <= 1'b1;
            @(posedge core_clk) scan_end <= 1'b0;
            wait_cyc(5);
            // Mid-check the DAC carries the corrected threshold
            if (i < 2)
                cmp("dac", 16'(32'h01D8 + corr), 16'(dac_code));
            wait_cyc(15);
            rd_reg(OFS_FAULT_2, rv);
            cmp("acc", i == 0 ? 16'h0002 : i == 1 ? 16'h0004 : 16'h0000,
                rv);
        end
        print_verdict();
    end
endmodule : testbench

/* verilog/diag_checks.sv */
// Purpose: Die temperature alert, diagnostic conversions, accuracy check
// Assumes: ADC and scan engine on core_clk; comparator output is a pin
// Notes:   Register port answers reads one cycle after the strobe
//
// What this block does
// - Check die temperature every 1 ms
// - Temperature above threshold sets overtemp flag
// - Select code 1 suspends periodic temperature monitoring
// - Code 2: reference measured against supply rail
// - Code 3: alternate reference against main reference
// - Alternate reference conversion forced unipolar
// - Code 4: reference into amp, DAC 0x1D8
// - Code 4: pre-amp output converted, stored
// - Accuracy check at scan end, configs 1/2
// - Check drives reference, DAC from thresholds
// - Overvoltage violation sets accuracy OV flag
// - Undervoltage violation sets accuracy UV flag
// - Ideal comparator at 1D8h: OV set, UV not
`timescale 1ns/1ns
module diag_checks
    import diag_pkg::*;
#(
    parameter int TICK_CYCLES = TEMP_CYCLES // 1 ms at 50 MHz
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    // Scan engine events
    input  wire logic        diag_req,
    input  wire logic        diag_slot,
    input  wire logic        scan_end,
    // ADC and analog front end
    output logic             adc_start,
    input  wire logic        adc_done,
    input  wire logic [13:0] adc_data,
    output afe_ctrl_t        afe,
    output logic      [9:0]  dac_code,
    input  wire logic        comp_pin,
    output logic             busy
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    typedef enum {ST_IDLE, ST_CONV, ST_ACC_OV, ST_ACC_UV} state_t;
    state_t      st_q;           // Sequencer state
    conv_kind_t  kind_q;         // What the running conversion is for
    logic [7:0]  diag_cfg_q;     // diag_select_second, diag_select_first
    logic [15:0] res1_q;         // diag_result_first
    logic [15:0] res2_q;         // diag_result_second
    logic [1:0]  acq_cfg_q;      // Calibration and accuracy enables
    logic [2:0]  scan_cfg_q;     // scan_configuration
    logic [13:0] temp_thr_q;     // Die temperature alert threshold
    logic [9:0]  acc_ov_q;       // accuracy_ov_threshold
    logic [9:0]  acc_uv_q;       // accuracy_uv_threshold
    logic [2:0]  fault_q;        // safety_fault_status_two
    logic [3:0]  settle_q;       // Comparator settling counter
    logic        temp_pend_q;    // Tick waiting for the sequencer
    logic        acc_pend_q;     // Scan end waiting for accuracy check
    logic        tick;           // 1 ms enable
    logic        comp_s;         // Synchronised comparator output
    logic        suspend;        // Temperature requested by software
    logic [3:0]  sel_pick;       // Select code of requested slot
    logic        sel_ok;         // Requested code is handled here
    logic        acc_ok;         // Accuracy check allowed for this scan
    logic        temp_over;      // Temperature conversion exceeded
    logic        set_ov;         // Accuracy OV event
    logic        set_uv;         // Accuracy UV event
    logic [2:0]  fault_set;      // All hardware set events
    logic        start_conv;     // Sequencer starts a conversion

    assign suspend = (diag_cfg_q[3:0] == SEL_TEMP) ||
                     (diag_cfg_q[7:4] == SEL_TEMP);
    assign sel_pick = diag_slot ? diag_cfg_q[7:4] : diag_cfg_q[3:0];
    assign sel_ok = (sel_pick >= SEL_TEMP) && (sel_pick <= SEL_PATH);
    assign acc_ok = acq_cfg_q[BIT_ACC_EN] &&
                    (scan_cfg_q == SCAN_CMP_A ||
                     scan_cfg_q == SCAN_CMP_B);
    assign temp_over = (st_q == ST_CONV) && (kind_q == K_TEMP) &&
                       adc_done && (adc_data > temp_thr_q);
    // Comparator high means input above DAC level: an OV violation,
    // low at the UV level is a UV violation. At 1D8h the ideal part
    // sits on the edge and resolves high.
    assign set_ov = (st_q == ST_ACC_OV) && (settle_q == 4'd0) &&
                    comp_s;
    assign set_uv = (st_q == ST_ACC_UV) && (settle_q == 4'd0) &&
                    !comp_s;
    assign fault_set = {set_uv, set_ov, temp_over};
    assign start_conv = (st_q == ST_IDLE) && !acc_pend_q &&
                        (diag_req ? sel_ok : temp_pend_q && !suspend);

    // ------------------------------------------------------------------
    // Helpers: 1 ms divider and comparator synchroniser
    // ------------------------------------------------------------------
    tick_div #(.PERIOD(TICK_CYCLES)) u_tick (
        .core_clk (core_clk),
        .resetn   (resetn),
        .tick     (tick)
    );
    sync2 u_comp (
        .core_clk (core_clk),
        .resetn   (resetn),
        .d        (comp_pin),
        .q        (comp_s)
    );

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    // Plain configuration writes
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            diag_cfg_q <= 8'h00;
            acq_cfg_q  <= 2'b00;
            scan_cfg_q <= 3'b000;
            temp_thr_q <= TEMP_THR_RST;
            acc_ov_q   <= ACC_THR_RST;
            acc_uv_q   <= ACC_THR_RST;
        end else if (wr) begin
            case (addr)
                OFS_DIAG_CONFIG: diag_cfg_q <= wdata[7:0];
                OFS_ACQ_CONFIG:  acq_cfg_q  <= wdata[1:0];
                OFS_SCAN_CTRL:   scan_cfg_q <= wdata[2:0];
                OFS_TEMP_THR:    temp_thr_q <= wdata[13:0];
                OFS_ACC_OV_THR:  acc_ov_q   <= wdata[9:0];
                OFS_ACC_UV_THR:  acc_uv_q   <= wdata[9:0];
                default: ;       // Read-only or unmapped: ignored
            endcase
        end
    end

    // Sticky alert flags: write one to clear, a set in the same cycle
    // wins so no event is lost
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fault_q <= 3'b000;
        end else begin
            if (wr && addr == OFS_FAULT_2)
                fault_q <= (fault_q & ~wdata[2:0]) | fault_set;
            else
                fault_q <= fault_q | fault_set;
        end
    end

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            case (addr)
                OFS_DIAG_CONFIG: rdata <= {8'h00, diag_cfg_q};
                OFS_RESULT_1:    rdata <= res1_q;
                OFS_RESULT_2:    rdata <= res2_q;
                OFS_ACQ_CONFIG:  rdata <= {14'h0000, acq_cfg_q};
                OFS_SCAN_CTRL:   rdata <= {13'h0000, scan_cfg_q};
                OFS_TEMP_THR:    rdata <= {2'b00, temp_thr_q};
                OFS_ACC_OV_THR:  rdata <= {6'h00, acc_ov_q};
                OFS_ACC_UV_THR:  rdata <= {6'h00, acc_uv_q};
                OFS_FAULT_2:     rdata <= {13'h0000, fault_q};
                default:         rdata <= 16'h0000; // Unmapped
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // Pending work
    // ------------------------------------------------------------------
    // A tick is held until the sequencer is free; a tick that lands
    // while software owns the temperature path is dropped
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            temp_pend_q <= 1'b0;
        end else if (suspend) begin
            temp_pend_q <= 1'b0;
        end else if (tick) begin
            temp_pend_q <= 1'b1;
        end else if (start_conv && !diag_req) begin
            temp_pend_q <= 1'b0;
        end
    end

    // Scan end arms the accuracy check only for comparator scans
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            acc_pend_q <= 1'b0;
        end else if (scan_end && acc_ok) begin
            acc_pend_q <= 1'b1;
        end else if (st_q == ST_IDLE) begin
            acc_pend_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Priority: accuracy check, then diagnostic request, then the
    // periodic temperature check
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q     <= ST_IDLE;
            kind_q   <= K_TEMP;
            settle_q <= 4'd0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (acc_pend_q) begin
                        st_q     <= ST_ACC_OV;
                        settle_q <= 4'(SETTLE_CYCLES - 1);
                    end else if (start_conv) begin
                        st_q   <= ST_CONV;
                        kind_q <= !diag_req ? K_TEMP :
                                  diag_slot ? K_DIAG2 : K_DIAG1;
                    end
                end
                ST_CONV: begin
                    if (adc_done)
                        st_q <= ST_IDLE;
                end
                ST_ACC_OV: begin
                    if (settle_q != 4'd0) begin
                        settle_q <= settle_q - 4'd1;
                    end else begin
                        st_q     <= ST_ACC_UV;
                        settle_q <= 4'(SETTLE_CYCLES - 1);
                    end
                end
                ST_ACC_UV: begin
                    if (settle_q != 4'd0)
                        settle_q <= settle_q - 4'd1;
                    else
                        st_q <= ST_IDLE;
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Front-end steering, held for the whole conversion or check; DAC steps from OV to UV threshold mid-check
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            afe       <= '{IN_NONE, 1'b0, 1'b0, 1'b0};
            dac_code  <= 10'h000;
            adc_start <= 1'b0;
        end else begin
            adc_start <= 1'b0;
            if (st_q == ST_IDLE && acc_pend_q) begin
                afe      <= '{IN_NONE, 1'b0, 1'b0, 1'b1};
                dac_code <= acc_ov_q;
            end else if (st_q == ST_ACC_OV && settle_q == 4'd0) begin
                dac_code <= acc_uv_q;
            end else if (start_conv) begin
                adc_start <= 1'b1;
                dac_code  <= 10'h000;
                case (diag_req ? sel_pick : SEL_TEMP)
                    SEL_TEMP:
                        afe <= '{IN_TEMPERATURE_PROPORTIONAL_SOURCE, 1'b0, 1'b0, 1'b0};
                    SEL_VAA:
                        afe <= '{IN_VREF, 1'b1, 1'b0, 1'b0};
                    SEL_ALTERNATE_REFERENCE: begin
                        // Main reference as ADC reference, unipolar
                        afe <= '{IN_ALTERNATE_REFERENCE, 1'b0, 1'b1, 1'b0};
                    end
                    SEL_PATH: begin
                        afe <= '{IN_PREAMP, 1'b0, 1'b0, 1'b1};
                        dac_code <= PATH_DAC_CODE;
                    end
                    default:
                        afe <= '{IN_NONE, 1'b0, 1'b0, 1'b0};
                endcase
            end else if (st_q == ST_IDLE || (st_q == ST_ACC_UV &&
                                             settle_q == 4'd0)) begin
                afe      <= '{IN_NONE, 1'b0, 1'b0, 1'b0};
                dac_code <= 10'h000;
            end
        end
    end

    // Busy flag mirrors the sequencer for the scan engine
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            busy <= 1'b0;
        else
            busy <= (st_q != ST_IDLE) || start_conv || acc_pend_q;
    end

    // ------------------------------------------------------------------
    // Result capture, 14 bits left aligned
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            res1_q <= 16'h0000;
            res2_q <= 16'h0000;
        end else if (st_q == ST_CONV && adc_done) begin
            if (kind_q == K_DIAG1)
                res1_q <= {adc_data, 2'b00};
            if (kind_q == K_DIAG2)
                res2_q <= {adc_data, 2'b00};
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_temp_suspended: assert property (
        adc_start && afe.in_sel == IN_TEMPERATURE_PROPORTIONAL_SOURCE && !$past(diag_req)
        |-> !$past(suspend))
        else $error("temperature check ran while suspended");
    a_temp_alert_set: assert property (
        temp_over |=> fault_q[BIT_F_TEMP])
        else $error("overtemp flag not set");
    a_vaa_reference: assert property (
        adc_start && afe.in_sel == IN_VREF |-> afe.ref_vaa
        ##1 (afe.ref_vaa throughout (st_q == ST_CONV)))
        else $error("supply check without supply reference");
    a_alternate_reference_unipolar: assert property (
        st_q == ST_CONV && afe.in_sel == IN_ALTERNATE_REFERENCE |-> afe.force_unip)
        else $error("alternate reference not unipolar");
    a_path_dac_code: assert property (
        st_q == ST_CONV && afe.in_sel == IN_PREAMP
        |-> dac_code == PATH_DAC_CODE && afe.second_level_shift_amp_vref)
        else $error("path diagnostic DAC code wrong");
    a_result_store: assert property (
        st_q == ST_CONV && kind_q == K_DIAG1 && adc_done
        |=> res1_q == {$past(adc_data), 2'b00})
        else $error("first result not stored aligned");
    a_acc_gated: assert property (
        scan_end && !acc_ok && st_q == ST_IDLE && !acc_pend_q
        |=> !acc_pend_q ##1 st_q != ST_ACC_OV)
        else $error("accuracy check ran without enable");
    a_acc_ov_dac: assert property (
        st_q == ST_ACC_OV |-> dac_code == acc_ov_q && afe.second_level_shift_amp_vref)
        else $error("accuracy OV stage drives wrong DAC");
    a_acc_ov_flag: assert property (
        st_q == ST_ACC_OV && settle_q == 4'd0 && comp_s
        |=> fault_q[BIT_F_ACC_OV])
        else $error("accuracy OV flag not set");
    a_acc_uv_flag: assert property (
        st_q == ST_ACC_UV && settle_q == 4'd0 && !comp_s
        |=> fault_q[BIT_F_ACC_UV])
        else $error("accuracy UV flag not set");
    a_acc_length: assert property (
        st_q == ST_IDLE ##1 st_q == ST_ACC_OV
        |-> ##[1:20] st_q == ST_IDLE)
        else $error("accuracy check did not finish");

    c_temp_alert: cover property (temp_over);
    c_path_diag: cover property (adc_start && afe.in_sel == IN_PREAMP);
    c_acc_check: cover property (st_q == ST_ACC_UV ##1 st_q == ST_IDLE);
endmodule : diag_checks

/* verilog/sync2.sv */
// Purpose: Two-stage synchroniser for one level
// Assumes: Input is asynchronous to core_clk
// Notes:   Only the second stage may be read outside this module
`timescale 1ns/1ns
module sync2 (
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire logic d,
    output logic      q
);
    logic meta_q; // First stage, read by the second stage only

    // ------------------------------------------------------------------
    // Two flops in series
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : sync2

/* verilog/tick_div.sv */
// Purpose: Divider that emits a one-cycle enable every PERIOD cycles
// Assumes: PERIOD at least 2
// Notes:   Free running from reset release
`timescale 1ns/1ns
module tick_div #(
    parameter int PERIOD = 50000
) (
    input  wire logic core_clk,
    input  wire logic resetn,
    output logic      tick
);
    logic [31:0] cnt_q; // Cycles since last tick

    // ------------------------------------------------------------------
    // Count up the period, pulse at the wrap
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else if (cnt_q == 32'(PERIOD - 1)) begin
            cnt_q <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'd1;
            tick  <= 1'b0;
        end
    end
endmodule : tick_div
